// file: core/ubdc_burst_ctrl.sv
/*
 * burst control of an ultrasonic transformer driver: burst sequencing, pulse counting, blank-out,
 * stuck-drive and pulse-count diagnostics, drive phase select, apb register file
 * assumes a 100 mhz pclk, an apb master on the same clock, and asynchronous control pins
 */
// Decided for this implementation: the APB register port and the register addresses.
`default_nettype none

`include "ubdc_params.svh"

// Operation
// - burst mode comes from the mode field of the control register
// - after enable, burst starts at next falling edge of the clock pin
// - mode 3: one falling edge of clock pin enables and starts the burst
// - one pulse counted per falling-to-falling interval of the clock pin
// - mode 3: burst ends when the pulse count reaches the programmed value
// - mode 3: blank-out interval after burst ignores clock pin toggling
// - during a burst, drive outputs follow the two control pins
// - modes 0 and 1: count 0 bursts continuously until command or gate pin ends
// - mode 3 never bursts continuously; count is always enforced
// - when not bursting, the block is listening
// - modes 0,1,3: shortfall of pulses at end of burst sets pulse-count fault
// - no pin toggle within the stuck window sets the stuck-drive fault
// - a stuck-drive trip forces the burst to end at once
// - stuck-drive before all pulses also sets the pulse-count fault
// - stuck fault clears on new burst start, window code 7, or standby
// - pulse-count fault clears only on new burst start or standby
// - in-phase select clear drives switch a from the gate pin and switch b from the clock pin
// - in-phase select set drives both switches together, same current limit
// - current limit level follows the current limit select field
module ubdc_burst_ctrl
    import ubdc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        gate_pin_a,
    input  wire logic        clock_pin_b,
    output logic             low_side_drain_a,
    output logic             low_side_drain_b,
    output logic [1:0]       drive_current_limit,
    output logic             listening
);
    logic        a_level;
    logic        a_fall;
    logic        a_rise;
    logic        b_level;
    logic        b_fall;
    logic        b_rise;
    logic [31:0] ctrl_reg;
    logic [7:0]  burst_count_reg;
    logic [2:0]  stuck_pulse_window_reg;
    logic        pulse_count_fault_reg;
    logic        stuck_drive_fault_reg;
    ubdc_state_e state_reg;
    logic [7:0]  pulses_reg;
    logic        trig_seen_reg;
    logic [15:0] timer_reg;
    logic        drive_a_reg;
    logic        drive_b_reg;
    logic [31:0] rdata_next;
    logic        wr;
    logic        mapped;

    ubdc_mode_e  mode;
    logic        trigger;
    logic        in_phase_drive_select;
    logic        standby;
    logic        enable_evt;
    logic        start_evt;
    logic        count_done;
    logic        early_end;
    logic        toggle;
    logic        stuck_trip;
    logic        end_evt;
    logic        short_count;
    logic [15:0] window_cycles;

    // window length in cycles for a 3-bit code, used for stuck check and blank-out
    function automatic logic [15:0] win_cycles(input logic [2:0] code);
        logic [31:0] prod;
        prod = (32'(code) + 32'd1) * 32'(`UBDC_WIN_STEP_CYC);
        return prod[15:0];
    endfunction

    // address decode for the pslverr response; read mux and write strobes compare paddr themselves
    function automatic logic is_mapped(input logic [11:0] a);
        return a == `UBDC_CTRL_OFS || a == `UBDC_COUNT_OFS || a == `UBDC_WINDOW_OFS || a == `UBDC_STATUS_OFS;
    endfunction

    // pin synchronisers
    ubdc_pin_sync u_sync_a (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (gate_pin_a),
        .level   (a_level),
        .fall    (a_fall),
        .rise    (a_rise)
    );

    ubdc_pin_sync u_sync_b (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (clock_pin_b),
        .level   (b_level),
        .fall    (b_fall),
        .rise    (b_rise)
    );

    // control field decode
    assign mode                  = ubdc_mode_e'(ctrl_reg[`UBDC_CTRL_MODE_LSB +: 2]);
    assign trigger               = ctrl_reg[`UBDC_CTRL_TRIG_BIT];
    assign in_phase_drive_select = ctrl_reg[`UBDC_CTRL_PHASE_BIT];
    assign standby               = ctrl_reg[`UBDC_CTRL_STBY_BIT];
    assign window_cycles         = win_cycles(stuck_pulse_window_reg);

    // apb: zero-wait slave, unmapped address answers pslverr
    assign wr      = psel & penable & pwrite;
    assign mapped  = is_mapped(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // enable event per mode; direct mode is outside this block and never arms a burst
    always_comb begin
        case (mode)
            UBDC_MODE_SPI:  enable_evt = trigger & ~trig_seen_reg;
            UBDC_MODE_GATE: enable_evt = a_fall;
            UBDC_MODE_EDGE: enable_evt = b_fall;
            default:        enable_evt = 1'b0;
        endcase
    end

    // start from listen (mode 3, same edge) or from armed on the next clock pin fall
    assign start_evt = (state_reg == UBDC_ARMED && b_fall)
                     || (state_reg == UBDC_LISTEN && mode == UBDC_MODE_EDGE && b_fall && !standby);

    // a zero count means continuous only outside mode 3
    assign count_done  = (burst_count_reg != 8'h00 || mode == UBDC_MODE_EDGE)
                       && b_fall && (pulses_reg + 8'h01 >= burst_count_reg);
    assign early_end   = (mode == UBDC_MODE_SPI && !trigger)
                       || (mode == UBDC_MODE_GATE && a_rise) || standby;
    assign toggle      = a_fall | a_rise | b_fall | b_rise;
    assign stuck_trip  = state_reg == UBDC_BURST && !toggle && timer_reg >= window_cycles;
    assign end_evt     = state_reg == UBDC_BURST && (count_done || early_end || stuck_trip);
    assign short_count = burst_count_reg != 8'h00 && pulses_reg < burst_count_reg && !count_done;

    // burst sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= UBDC_LISTEN;
        end else begin
            case (state_reg)
                UBDC_LISTEN: begin
                    if (start_evt) begin
                        state_reg <= UBDC_BURST;
                    end else if (enable_evt && mode != UBDC_MODE_EDGE && !standby) begin
                        state_reg <= UBDC_ARMED;
                    end
                end
                UBDC_ARMED: begin
                    if (standby || (mode == UBDC_MODE_SPI && !trigger) || (mode == UBDC_MODE_GATE && a_rise)) begin
                        state_reg <= UBDC_LISTEN;
                    end else if (start_evt) begin
                        state_reg <= UBDC_BURST;
                    end
                end
                UBDC_BURST: begin
                    if (end_evt) begin
                        state_reg <= (mode == UBDC_MODE_EDGE) ? UBDC_BLANK : UBDC_LISTEN;
                    end
                end
                UBDC_BLANK: begin
                    if (timer_reg >= window_cycles) begin
                        state_reg <= UBDC_LISTEN;
                    end
                end
                default: state_reg <= UBDC_LISTEN;
            endcase
        end
    end

    // spi-mode trigger needs a low-high cycle before another burst may be enabled;
    // it is consumed only when listening, so a trigger raised during blank-out stays pending
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_seen_reg <= 1'b0;
        end else if (!trigger) begin
            trig_seen_reg <= 1'b0;
        end else if (enable_evt && state_reg == UBDC_LISTEN && !standby) begin
            trig_seen_reg <= 1'b1;
        end
    end

    // pulse counter, falling edge to falling edge of the clock pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulses_reg <= 8'h00;
        end else if (start_evt) begin
            pulses_reg <= 8'h00;
        end else if (state_reg == UBDC_BURST && b_fall && pulses_reg != 8'hff) begin
            pulses_reg <= pulses_reg + 8'h01;
        end
    end

    // one timer serves the stuck window during a burst and the blank-out afterwards;
    // toggles restart only the stuck window, so a free-running clock cannot stretch blank-out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_reg <= 16'h0000;
        end else if (start_evt || end_evt || (toggle && state_reg == UBDC_BURST)) begin
            timer_reg <= 16'h0000;
        end else if ((state_reg == UBDC_BURST || state_reg == UBDC_BLANK) && timer_reg != 16'hffff) begin
            timer_reg <= timer_reg + 16'h0001;
        end
    end

    // drive outputs: off outside a burst so no switch stays on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_a_reg <= 1'b0;
            drive_b_reg <= 1'b0;
        end else if ((state_reg == UBDC_BURST && !end_evt) || start_evt) begin
            if (in_phase_drive_select) begin
                drive_a_reg <= ~b_level;
                drive_b_reg <= ~b_level;
            end else begin
                drive_a_reg <= ~a_level;
                drive_b_reg <= ~b_level;
            end
        end else begin
            drive_a_reg <= 1'b0;
            drive_b_reg <= 1'b0;
        end
    end

    assign low_side_drain_a    = drive_a_reg;
    assign low_side_drain_b    = drive_b_reg;
    assign drive_current_limit = ctrl_reg[`UBDC_CTRL_ILIM_LSB +: 2];
    assign listening           = state_reg != UBDC_BURST;

    // pulse-count fault: set beats clear, since a start can never coincide with an end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_count_fault_reg <= 1'b0;
        end else if (end_evt && short_count && mode != UBDC_MODE_DIRECT) begin
            pulse_count_fault_reg <= 1'b1;
        end else if (start_evt || standby) begin
            pulse_count_fault_reg <= 1'b0;
        end
    end

    // stuck-drive fault with its three clear sources
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stuck_drive_fault_reg <= 1'b0;
        end else if (stuck_trip) begin
            stuck_drive_fault_reg <= 1'b1;
        end else if (start_evt || standby || (wr && paddr == `UBDC_WINDOW_OFS && pstrb[0]
                     && pwdata[2:0] == `UBDC_WIN_CLEAR_CODE)) begin
            stuck_drive_fault_reg <= 1'b0;
        end
    end

    // writable registers, byte lane 0 only carries the narrow fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg               <= `UBDC_CTRL_RST;
            burst_count_reg        <= `UBDC_COUNT_RST;
            stuck_pulse_window_reg <= `UBDC_WINDOW_RST;
        end else if (wr && pstrb[0]) begin
            if (paddr == `UBDC_CTRL_OFS) begin
                ctrl_reg <= {25'h0, pwdata[6:0]};
            end
            if (paddr == `UBDC_COUNT_OFS) begin
                burst_count_reg <= pwdata[7:0];
            end
            if (paddr == `UBDC_WINDOW_OFS) begin
                stuck_pulse_window_reg <= pwdata[2:0];
            end
        end
    end

    // read mux
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (paddr)
            `UBDC_CTRL_OFS:   rdata_next = ctrl_reg;
            `UBDC_COUNT_OFS:  rdata_next = {24'h0, burst_count_reg};
            `UBDC_WINDOW_OFS: rdata_next = {29'h0, stuck_pulse_window_reg};
            `UBDC_STATUS_OFS: rdata_next = {28'h0, state_reg == UBDC_BLANK, state_reg == UBDC_BURST,
                                            stuck_drive_fault_reg, pulse_count_fault_reg};
            default:          rdata_next = 32'h0000_0000;
        endcase
    end

    // read data registered at the setup cycle so it is valid through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_next;
        end
    end

endmodule

`default_nettype wire

// file: core/ubdc_params.svh
/*
 * constants of the ultrasonic burst drive control: register offsets, field positions, reset values, timing
 * assumes inclusion by bare name from core and bench files
 */
`ifndef UBDC_PARAMS_SVH
`define UBDC_PARAMS_SVH

// register byte addresses on the apb bus
`define UBDC_CTRL_OFS       12'h000
`define UBDC_COUNT_OFS      12'h004
`define UBDC_WINDOW_OFS     12'h008
`define UBDC_STATUS_OFS     12'h00c

// control register fields
`define UBDC_CTRL_MODE_LSB  0
`define UBDC_CTRL_TRIG_BIT  2
`define UBDC_CTRL_PHASE_BIT 3
`define UBDC_CTRL_ILIM_LSB  4
`define UBDC_CTRL_STBY_BIT  6

// status register fields
`define UBDC_ST_CNTF_BIT    0
`define UBDC_ST_STKF_BIT    1
`define UBDC_ST_BURST_BIT   2
`define UBDC_ST_BLANK_BIT   3

// reset values and the window clear code
`define UBDC_CTRL_RST       32'h0000_0000
`define UBDC_COUNT_RST      8'h00
`define UBDC_WINDOW_RST     3'h0
`define UBDC_WIN_CLEAR_CODE 3'h7

// stuck-pulse window base time: step 1 us, window = (code + 1) steps
`define UBDC_WIN_STEP_NS    1000
`define UBDC_CLK_NS         10
`define UBDC_WIN_STEP_CYC   ((`UBDC_WIN_STEP_NS + `UBDC_CLK_NS - 1) / `UBDC_CLK_NS)

`endif

// file: core/ubdc_pin_sync.sv
/*
 * two-flop synchroniser with edge detect for one control pin
 * assumes the pin is asynchronous to pclk; the first flop feeds only the second
 */
`default_nettype none

module ubdc_pin_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      level,
    output logic      fall,
    output logic      rise
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // idle pins rest high, so reset to one to avoid a false falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign fall  = last_reg & ~sync_reg;
    assign rise  = ~last_reg & sync_reg;
endmodule

`default_nettype wire

// file: core/ubdc_pkg.sv
/*
 * types of the ultrasonic burst drive control
 * assumes nothing beyond a systemverilog compiler
 */
`default_nettype none

package ubdc_pkg;

    // burst operating modes held in the control register
    typedef enum logic [1:0] {
        UBDC_MODE_SPI,
        UBDC_MODE_GATE,
        UBDC_MODE_DIRECT,
        UBDC_MODE_EDGE
    } ubdc_mode_e;

    // burst sequencer states
    typedef enum logic [1:0] {
        UBDC_LISTEN,
        UBDC_ARMED,
        UBDC_BURST,
        UBDC_BLANK
    } ubdc_state_e;

endpackage

`default_nettype wire

// file: verif/ubdc_assertions.sv
/* concurrent checks on the burst control ports
   assumes binding onto ubdc_burst_ctrl, one pclk domain, presetn asynchronous active low */
`default_nettype none
module ubdc_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        gate_pin_a,
    input wire logic        clock_pin_b,
    input wire logic        low_side_drain_a,
    input wire logic        low_side_drain_b,
    input wire logic [1:0]  drive_current_limit,
    input wire logic        listening
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0]  pins_reg;
    logic [10:0] quiet_reg;

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    // burst cycles since either pin moved; widest window is 800 cycles plus sync latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_reg <= 2'h3;
            quiet_reg <= 11'h000;
        end else begin
            pins_reg <= {gate_pin_a, clock_pin_b};
            if (listening || pins_reg != {gate_pin_a, clock_pin_b})
                quiet_reg <= 11'h000;
            else if (quiet_reg != 11'h7ff)
                quiet_reg <= quiet_reg + 11'h001;
        end
    end

    // bus phases and the pin history that must precede a burst start
    sequence s_acc; psel && penable; endsequence
    sequence s_ctrl_wr; psel && penable && pwrite && paddr == 12'h000 && pstrb[0]; endsequence
    sequence s_pin_low; !$past(clock_pin_b, 3) || !$past(clock_pin_b, 4) || !$past(clock_pin_b, 5); endsequence

    property p_ready; s_acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access phase");
    property p_refuse; s_acc ##0 (paddr > 12'h00c) |-> pslverr && (pwrite || prdata == 32'h0); endproperty
    a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
    property p_mapped; s_acc ##0 (paddr <= 12'h00c && paddr[1:0] == 2'h0) |-> !pslverr; endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_limit; s_ctrl_wr |=> drive_current_limit == $past(pwdata[5:4]); endproperty
    a_limit: assert property (p_limit) else $error("current limit not taken from write");
    property p_limit_hold; !$stable(drive_current_limit) |-> $past(psel && penable && pwrite && paddr == 12'h000);
    endproperty
    a_limit_hold: assert property (p_limit_hold) else $error("current limit moved unprompted");
    property p_idle_off; listening && $past(listening) |-> !low_side_drain_a && !low_side_drain_b; endproperty
    a_idle_off: assert property (p_idle_off) else $error("drive on while listening");
    property p_start; $fell(listening) |-> s_pin_low; endproperty
    a_start: assert property (p_start) else $error("burst began without clock pin fall");
    property p_stuck; quiet_reg <= 11'h334; endproperty
    a_stuck: assert property (p_stuck) else $error("stuck pin did not end burst");
    property p_rdata; !$stable(prdata) |-> $past(psel && !penable && !pwrite); endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved outside read setup");
endmodule

bind ubdc_burst_ctrl ubdc_chk ubdc_chk_inst (.*);
`default_nettype wire

// file: verif/ubdc_burst_ctrl_bench.sv
/* bench of the burst control: apb tasks, pin model, mode 3, stuck and continuous tests
   assumes ubdc_params.svh on the include path and the checker bound in */
`default_nettype none
`include "ubdc_params.svh"
module ubdc_burst_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, run, gate_lvl;
    logic        gate_pin_a, clock_pin_b, low_side_drain_a, low_side_drain_b, listening;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  pstrb;
    logic [1:0]  drive_current_limit;
    int          bad_count, n_tests, ah, bh, df, gap, len;

    // 100 mhz pclk
    always #5 pclk = ~pclk;

    ubdc_burst_ctrl ubdc_burst_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gate_pin_a(gate_pin_a), .clock_pin_b(clock_pin_b),
        .low_side_drain_a(low_side_drain_a), .low_side_drain_b(low_side_drain_b),
        .drive_current_limit(drive_current_limit), .listening(listening));
    ubdc_mcu #(.HALF(20)) ubdc_mcu_inst (.*);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("counts: %0d compared, %0d mismatched", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one apb transfer; request held until pready is sampled high, then an idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            conclude();
        end
        @(posedge pclk);
    endtask

    // waits for listening to reach v, tallying drain levels on the way
    task automatic wait_lst(input logic v, output int c);
        c = 0;
        do begin
            @(negedge pclk);
            c++;
            ah += int'(low_side_drain_a === 1'b1);
            bh += int'(low_side_drain_b === 1'b1);
            df += int'(low_side_drain_a !== low_side_drain_b);
        end while (listening !== v && c < 3000);
        if (listening !== v) begin
            bad_count++;
            conclude();
        end
        @(posedge pclk);
    endtask

    // one whole burst: gap before it, then its length
    task automatic burst();
        ah = 0;
        bh = 0;
        df = 0;
        wait_lst(1'b0, gap);
        wait_lst(1'b1, len);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, run} = 4'h0;
        gate_lvl = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // all four registers reset to zero; unmapped word refused
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check(q, 32'h0);
        end
        check(listening, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        check(32'(err), 32'h1);
        check(q, 32'h0);
        $display("test reset done");
        // mode 3, four pulses, shortest window, out of phase then in phase
        apb(1'b1, `UBDC_COUNT_OFS, 32'h4);
        apb(1'b1, `UBDC_CTRL_OFS, 32'h23);
        check(drive_current_limit, 2'h2);
        run <= 1'b1;
        burst();
        check(32'(len >= 150 && len <= 170), 32'h1);
        check({ah == 0, bh > 0}, 2'h3);
        burst();
        check(32'(gap >= 100 && gap <= 140), 32'h1);
        apb(1'b1, `UBDC_CTRL_OFS, 32'h2b);
        burst();
        check({df == 0, bh > 0}, 2'h3);
        check(drive_current_limit, 2'h2);
        $display("test edge mode done");
        // clock stops mid-burst: stuck trip ends the burst and flags both faults
        wait_lst(1'b0, gap);
        run <= 1'b0;
        wait_lst(1'b1, len);
        check(32'(len >= 90 && len <= 120), 32'h1);
        apb(1'b0, `UBDC_STATUS_OFS, 32'h0);
        check(q & 32'h7, 32'h3);
        apb(1'b1, `UBDC_WINDOW_OFS, 32'(`UBDC_WIN_CLEAR_CODE));
        apb(1'b0, `UBDC_STATUS_OFS, 32'h0);
        check(q & 32'h3, 32'h1);
        apb(1'b1, `UBDC_CTRL_OFS, 32'h6b);
        apb(1'b0, `UBDC_STATUS_OFS, 32'h0);
        check(q & 32'h3, 32'h0);
        apb(1'b1, `UBDC_WINDOW_OFS, 32'h0);
        apb(1'b1, `UBDC_COUNT_OFS, 32'h0);
        $display("test stuck done");
        // count 0 bursts on in modes 0 and 1 until trigger clear or gate pin rise
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, `UBDC_CTRL_OFS, (m == 0) ? 32'h24 : 32'h21);
            gate_lvl <= (m == 0);
            run <= 1'b1;
            wait_lst(1'b0, gap);
            repeat (300) @(posedge pclk);
            apb(1'b0, `UBDC_STATUS_OFS, 32'h0);
            check(q & 32'h4, 32'h4);
            if (m == 0)
                apb(1'b1, `UBDC_CTRL_OFS, 32'h20);
            else
                gate_lvl <= 1'b1;
            wait_lst(1'b1, len);
            check(32'(len <= 10), 32'h1);
            apb(1'b0, `UBDC_STATUS_OFS, 32'h0);
            check(q & 32'h3, 32'h0);
            run <= 1'b0;
        end
        $display("test continuous done");
        conclude();
    end
endmodule
`default_nettype wire

// file: verif/ubdc_mcu.sv
/* pin-side controller model: gate pin level and a burst clock on the clock pin
   assumes pclk paces it; HALF is the clock pin half period in pclk cycles */
`default_nettype none
module ubdc_mcu #(
    parameter int HALF = 20
) (
    input  wire logic pclk,
    input  wire logic run,
    input  wire logic gate_lvl,
    output logic      gate_pin_a,
    output logic      clock_pin_b
);
    timeunit 1ns;
    timeprecision 1ns;
    int tick;

    // pins rest high from time zero so no stray falling edge reaches the block
    initial begin
        gate_pin_a = 1'b1;
        clock_pin_b = 1'b1;
        tick = 0;
    end

    // clock pin toggles every HALF cycles while run is high, and rests high otherwise
    always @(posedge pclk) begin
        gate_pin_a <= gate_lvl;
        tick <= run ? (tick + 1) % HALF : 0;
        if (!run)
            clock_pin_b <= 1'b1;
        else if (tick == HALF - 1)
            clock_pin_b <= ~clock_pin_b;
    end
endmodule
`default_nettype wire
